/* File: rtl/adb_pkg.sv */
package adb_pkg;

    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_ENABLE   = 10'h00c6;
    localparam logic [9:0] IDX_CTRL     = 10'h00c7;
    localparam logic [9:0] IDX_THR_AD   = 10'h00c8;
    localparam logic [9:0] IDX_THR_DB   = 10'h00c9;
    localparam logic [9:0] IDX_STATUS   = 10'h00d0;

    // Reset values
    localparam logic [7:0] RST_CTRL     = 8'h34;
    localparam logic [7:0] RST_THR_AD   = 8'h0a;
    localparam logic [7:0] RST_THR_DB   = 8'h16;
    localparam logic       RST_ENABLE   = 1'b0;

    // Control register field positions
    localparam int REM_DEB_LSB  = 6;
    localparam int RATE_LSB     = 4;
    localparam int INS_DEB_LSB  = 1;
    localparam int PAUSE_BIT    = 0;

    // Status register bit positions
    localparam int ST_PRESENT   = 0;
    localparam int ST_DONE      = 1;
    localparam int ST_FOUR_POLE = 2;
    localparam int ST_BTN_A     = 3;
    localparam int ST_BTN_D     = 4;

    // Clock and millisecond tick
    localparam int CLK_PERIOD_NS = 40;
    localparam int NS_PER_MS     = 1000000;
    localparam int CYC_PER_MS    =
        (NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MS_W          = 10;

    // Interval tables in milliseconds
    localparam logic [9:0] REM_DEB_MS [4] =
        '{10'h001, 10'h005, 10'h00a, 10'h014};
    localparam logic [9:0] INS_DEB_MS [8] =
        '{10'h005, 10'h00a, 10'h014, 10'h032,
          10'h064, 10'h0c8, 10'h1f4, 10'h3e8};
    // Three-pole latency; four-pole runs a second phase of equal length
    localparam logic [9:0] DET_MS [4] =
        '{10'h020, 10'h040, 10'h080, 10'h100};
    localparam logic [9:0] BTN_PERIOD_MS = 10'h00a;

    typedef enum logic [2:0] {
        ADB_OFF     = 3'b000,
        ADB_ABSENT  = 3'b001,
        ADB_DEB_IN  = 3'b010,
        ADB_DET     = 3'b011,
        ADB_DET_PIN = 3'b100,
        ADB_PRESENT = 3'b101,
        ADB_DEB_OUT = 3'b110
    } adb_state_type;

    typedef struct packed {
        adb_state_type st;
        logic [7:0]    ctrl;
        logic [7:0]    thr_ad;
        logic [7:0]    thr_db;
        logic          en;
        logic          present;
        logic          four_pole;
        logic          done;
        logic          btn_a;
        logic          btn_d;
        logic          ins_evt;
        logic          rem_evt;
        logic          cmp_evt;
        logic          meas_req;
        logic          ramp_on;
        logic          restart;
        logic [9:0]    limit;
        logic [31:0]   prdata;
        logic          pready;
        logic          pslverr;
    } adb_main_type;

endpackage : adb_pkg

/* File: rtl/adb_timer_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface adb_timer_if;
    logic       restart;
    logic [9:0] limit_ms;
    logic       expired;

    modport ctrl  (output restart, output limit_ms, input expired);
    modport timer (input restart, input limit_ms, output expired);
endinterface : adb_timer_if
`default_nettype wire

/* File: rtl/adb_interval_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module adb_interval_timer
    import adb_pkg::*;
#(
    parameter int TICK_CYCLES = CYC_PER_MS
)(
    input  wire logic  pclk,
    input  wire logic  presetn,
    adb_timer_if.timer tif
);
    localparam int CW = $clog2(TICK_CYCLES + 1);
    localparam logic [CW-1:0] TICK_LAST = CW'(TICK_CYCLES - 1);

    typedef struct packed {
        logic [CW-1:0]   cyc;
        logic [MS_W-1:0] ms;
        logic            expired;
    } adb_timer_type;

    adb_timer_type t_reg;
    adb_timer_type t_next;

    // Millisecond counter; restart clears it so a bouncing pin starts over
    always_comb
    begin
        t_next = t_reg;
        if (tif.restart)
        begin
            t_next.cyc     = '0;
            t_next.ms      = '0;
            t_next.expired = 1'b0;
        end
        else
        begin
            if (t_reg.cyc == TICK_LAST)
            begin
                t_next.cyc = '0;
                // Saturate rather than wrap so a late look still sees expiry
                if (!t_reg.expired)
                    t_next.ms = t_reg.ms + 10'h001;
            end
            else
                t_next.cyc = t_reg.cyc + 1'b1;
            t_next.expired = (t_next.ms >= tif.limit_ms);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            t_reg <= '0;
        else
            t_reg <= t_next;
    end

    assign tif.expired = t_reg.expired;

endmodule : adb_interval_timer
`default_nettype wire

/* File: rtl/adb_accdet.sv */
// Summary of operation
// - Jack removal is accepted only after the pin stays low 1, 5, 10 or 20 ms as selected by a 2-bit field.
// - Jack insertion is accepted only after the pin stays high 5 ms to 1 s as selected by a 3-bit field.
// - A three-pole jack completes detection 32, 64, 128 or 256 ms after insertion per the rate field.
// - A four-pole jack completes detection 64, 128, 256 or 512 ms after insertion per the same field.
// - The latency is set by the ramp rate driven out to the mic sense current source.
// - The pause bit stops periodic button measurements; clear it to resume.
// - While paused, insertion and removal are still debounced and reported.
// - With the enable bit low no insertion or removal is detected at all.
// - A button code below the A/D threshold is button A.
// - A button code below the D/B threshold and not button A is button D.
// - One enable bit, reset low, turns the whole detection function on or off.
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module adb_accdet
    import adb_pkg::*;
#(
    parameter int TICK_CYCLES = CYC_PER_MS
)(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        jack_det_in,
    input  wire logic        mic_detect_in,
    input  wire logic        btn_valid_in,
    input  wire logic [7:0]  btn_code_in,
    output logic             jack_present,
    output logic             jack_four_pole,
    output logic             jack_inserted_evt,
    output logic             jack_removed_evt,
    output logic             detect_complete_evt,
    output logic             button_a_pressed,
    output logic             button_d_pressed,
    output logic             button_meas_req,
    output logic             mic_sense_ramp_on,
    output logic      [1:0]  mic_sense_ramp_rate
);

    adb_main_type q_reg;
    adb_main_type q_next;

    adb_timer_if tmr ();

    adb_interval_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .tif     (tmr)
    );

    // Timer is driven straight from registered fields
    assign tmr.restart  = q_reg.restart;
    assign tmr.limit_ms = q_reg.limit;

    // Field decode
    logic [1:0] rem_code;
    logic [1:0] rate_code;
    logic [2:0] ins_code;
    logic       paused;
    logic       tmr_done;
    logic       setup;
    logic       wr_take;
    logic [9:0] idx;

    assign rem_code  = q_reg.ctrl[REM_DEB_LSB +: 2];
    assign rate_code = q_reg.ctrl[RATE_LSB +: 2];
    assign ins_code  = q_reg.ctrl[INS_DEB_LSB +: 3];
    assign paused    = q_reg.ctrl[PAUSE_BIT];
    // Expiry is stale in the cycle the restart is still pending
    assign tmr_done  = tmr.expired && !q_reg.restart;
    assign setup     = psel && !penable;
    assign wr_take   = psel && penable && pready && pwrite;
    assign idx       = paddr[11:2];

    // True for every register index the slave answers
    function automatic logic mapped(input logic [9:0] i);
        mapped = (i == IDX_ENABLE) || (i == IDX_CTRL) ||
                 (i == IDX_THR_AD) || (i == IDX_THR_DB) ||
                 (i == IDX_STATUS);
    endfunction : mapped

    // Read value of one register index
    function automatic logic [7:0] read_reg(input logic [9:0] i,
                                           input adb_main_type s);
        logic [7:0] v;
        v = 8'h00;
        unique case (i)
            IDX_ENABLE: v[0] = s.en;
            IDX_CTRL:   v    = s.ctrl;
            IDX_THR_AD: v    = s.thr_ad;
            IDX_THR_DB: v    = s.thr_db;
            IDX_STATUS:
            begin
                v[ST_PRESENT]   = s.present;
                v[ST_DONE]      = s.done;
                v[ST_FOUR_POLE] = s.four_pole;
                v[ST_BTN_A]     = s.btn_a;
                v[ST_BTN_D]     = s.btn_d;
            end
            default:    v    = 8'h00;
        endcase
        read_reg = v;
    endfunction : read_reg

    always_comb
    begin
        q_next = q_reg;

        // Single-cycle strobes fall back every cycle
        q_next.ins_evt  = 1'b0;
        q_next.rem_evt  = 1'b0;
        q_next.cmp_evt  = 1'b0;
        q_next.meas_req = 1'b0;
        q_next.restart  = 1'b0;

        // APB: read data latched in setup, answer with no wait state
        q_next.pready  = setup;
        q_next.pslverr = setup && !mapped(idx);
        if (setup)
            q_next.prdata = {24'h0000_00, read_reg(idx, q_reg)};

        // Detection sequence
        unique case (q_reg.st)
            ADB_OFF:
            begin
                if (q_reg.en)
                begin
                    q_next.st      = ADB_ABSENT;
                    q_next.restart = 1'b1;
                end
            end
            ADB_ABSENT:
            begin
                // Insertion seen; start the insertion debounce
                if (jack_det_in)
                begin
                    q_next.st      = ADB_DEB_IN;
                    q_next.restart = 1'b1;
                    q_next.limit   = INS_DEB_MS[ins_code];
                end
            end
            ADB_DEB_IN:
            begin
                if (!jack_det_in)
                    q_next.st = ADB_ABSENT;
                else if (tmr_done)
                begin
                    q_next.st      = ADB_DET;
                    q_next.present = 1'b1;
                    q_next.ins_evt = 1'b1;
                    q_next.restart = 1'b1;
                    q_next.limit   = DET_MS[rate_code];
                    q_next.ramp_on = 1'b1;
                end
            end
            ADB_DET,
            ADB_DET_PIN:
            begin
                if (!jack_det_in)
                begin
                    q_next.st      = ADB_DEB_OUT;
                    q_next.restart = 1'b1;
                    q_next.limit   = REM_DEB_MS[rem_code];
                    q_next.ramp_on = 1'b0;
                end
                else if (tmr_done)
                begin
                    // A mic on the sleeve costs a second ramp phase
                    if (q_reg.st == ADB_DET && mic_detect_in)
                    begin
                        q_next.st        = ADB_DET_PIN;
                        q_next.four_pole = 1'b1;
                        q_next.restart   = 1'b1;
                    end
                    else
                    begin
                        q_next.st      = ADB_PRESENT;
                        q_next.done    = 1'b1;
                        q_next.cmp_evt = 1'b1;
                        q_next.ramp_on = 1'b0;
                        q_next.restart = 1'b1;
                        q_next.limit   = BTN_PERIOD_MS;
                    end
                end
            end
            ADB_PRESENT:
            begin
                // Removal is watched even while buttons are paused
                if (!jack_det_in)
                begin
                    q_next.st      = ADB_DEB_OUT;
                    q_next.restart = 1'b1;
                    q_next.limit   = REM_DEB_MS[rem_code];
                end
                else if (tmr_done)
                begin
                    q_next.restart  = 1'b1;
                    q_next.meas_req = q_reg.four_pole && !paused;
                end
            end
            ADB_DEB_OUT:
            begin
                if (jack_det_in)
                begin
                    // Pin came back early: back to PRESENT if done, else restart detection from the first phase
                    q_next.restart = 1'b1;
                    if (q_reg.done)
                    begin
                        q_next.st    = ADB_PRESENT;
                        q_next.limit = BTN_PERIOD_MS;
                    end
                    else
                    begin
                        q_next.st        = ADB_DET;
                        q_next.four_pole = 1'b0;
                        q_next.ramp_on   = 1'b1;
                        q_next.limit     = DET_MS[rate_code];
                    end
                end
                else if (tmr_done)
                begin
                    q_next.st        = ADB_ABSENT;
                    q_next.rem_evt   = 1'b1;
                    q_next.present   = 1'b0;
                    q_next.done      = 1'b0;
                    q_next.four_pole = 1'b0;
                    q_next.btn_a     = 1'b0;
                    q_next.btn_d     = 1'b0;
                end
            end
            default:
                q_next.st = ADB_OFF;
        endcase

        // Button classification, only on an unpaused four-pole jack
        if (btn_valid_in && q_reg.st == ADB_PRESENT &&
            q_reg.four_pole && !paused)
        begin
            q_next.btn_a = (btn_code_in < q_reg.thr_ad);
            q_next.btn_d = !(btn_code_in < q_reg.thr_ad) &&
                           (btn_code_in < q_reg.thr_db);
        end

        // Register writes take effect at the completing edge
        if (wr_take)
        begin
            unique case (idx)
                IDX_ENABLE: q_next.en     = pwdata[0];
                IDX_CTRL:   q_next.ctrl   = pwdata[7:0];
                IDX_THR_AD: q_next.thr_ad = pwdata[7:0];
                IDX_THR_DB: q_next.thr_db = pwdata[7:0];
                default:    q_next.en     = q_next.en;
            endcase
        end

        // Disabled: everything returns to rest and nothing is reported
        if (!q_reg.en)
        begin
            q_next.st        = ADB_OFF;
            q_next.present   = 1'b0;
            q_next.done      = 1'b0;
            q_next.four_pole = 1'b0;
            q_next.btn_a     = 1'b0;
            q_next.btn_d     = 1'b0;
            q_next.ins_evt   = 1'b0;
            q_next.rem_evt   = 1'b0;
            q_next.cmp_evt   = 1'b0;
            q_next.meas_req  = 1'b0;
            q_next.ramp_on   = 1'b0;
        end
    end

    // All state but the interval timer's counters in one register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q_reg        <= '0;
            q_reg.st     <= ADB_OFF;
            q_reg.ctrl   <= RST_CTRL;
            q_reg.thr_ad <= RST_THR_AD;
            q_reg.thr_db <= RST_THR_DB;
            q_reg.en     <= RST_ENABLE;
        end
        else
            q_reg <= q_next;
    end

    // Outputs straight from flops
    assign prdata              = q_reg.prdata;
    assign pready              = q_reg.pready;
    assign pslverr             = q_reg.pslverr;
    assign jack_present        = q_reg.present;
    assign jack_four_pole      = q_reg.four_pole;
    assign jack_inserted_evt   = q_reg.ins_evt;
    assign jack_removed_evt    = q_reg.rem_evt;
    assign detect_complete_evt = q_reg.cmp_evt;
    assign button_a_pressed    = q_reg.btn_a;
    assign button_d_pressed    = q_reg.btn_d;
    assign button_meas_req     = q_reg.meas_req;
    assign mic_sense_ramp_on   = q_reg.ramp_on;
    // Rate field scales the sense current ramp, hence the latency
    assign mic_sense_ramp_rate = q_reg.ctrl[RATE_LSB +: 2];

endmodule : adb_accdet
`default_nettype wire

/* File: tb/adb_accdet_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module adb_accdet_asserts
    import adb_pkg::*;
#(
    parameter int TICK_CYCLES = CYC_PER_MS
)(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        jack_det_in,
    input wire logic        btn_valid_in,
    input wire logic [7:0]  btn_code_in,
    input wire logic        jack_present,
    input wire logic        jack_four_pole,
    input wire logic        jack_inserted_evt,
    input wire logic        jack_removed_evt,
    input wire logic        detect_complete_evt,
    input wire logic        button_a_pressed,
    input wire logic        button_d_pressed,
    input wire logic        button_meas_req,
    input wire logic        mic_sense_ramp_on,
    input wire logic [1:0]  mic_sense_ramp_rate
);
    logic [7:0]  ctrl_reg;
    logic [7:0]  ad_reg;
    logic [7:0]  db_reg;
    logic        en_reg;
    logic [15:0] hi_cnt;
    logic [15:0] lo_cnt;
    logic [15:0] since_ins;
    logic [31:0] det_lo;
    logic        wr;

    // Shadows follow completed writes only, so refused cycles never count
    assign wr     = psel && penable && pready && pwrite;
    assign det_lo = DET_MS[ctrl_reg[5:4]] * TICK_CYCLES
                    * (jack_four_pole ? 2 : 1);

    // Register shadows and pin run-length counters
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg  <= RST_CTRL;
            ad_reg    <= RST_THR_AD;
            db_reg    <= RST_THR_DB;
            en_reg    <= RST_ENABLE;
            hi_cnt    <= 16'h0000;
            lo_cnt    <= 16'h0000;
            since_ins <= 16'h0000;
        end
        else
        begin
            if (wr && paddr[11:2] == IDX_CTRL) ctrl_reg <= pwdata[7:0];
            if (wr && paddr[11:2] == IDX_THR_AD) ad_reg <= pwdata[7:0];
            if (wr && paddr[11:2] == IDX_THR_DB) db_reg <= pwdata[7:0];
            if (wr && paddr[11:2] == IDX_ENABLE) en_reg <= pwdata[0];
            hi_cnt    <= jack_det_in ? hi_cnt + 16'h0001 : 16'h0000;
            lo_cnt    <= jack_det_in ? 16'h0000 : lo_cnt + 16'h0001;
            since_ins <= jack_inserted_evt ? 16'h0001
                                           : since_ins + 16'h0001;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ins_debounce: assert property (
        jack_inserted_evt |-> hi_cnt >= INS_DEB_MS[ctrl_reg[3:1]] * TICK_CYCLES)
        else $error("insertion reported before the pin settled");
    a_rem_debounce: assert property (
        jack_removed_evt |-> lo_cnt >= REM_DEB_MS[ctrl_reg[7:6]] * TICK_CYCLES)
        else $error("removal reported before the pin settled");
    a_det_latency: assert property (
        detect_complete_evt |-> since_ins >= det_lo
                                && since_ins <= det_lo + 2 * TICK_CYCLES + 6)
        else $error("detection latency outside its window");
    a_ramp_rate_follows: assert property (
        $stable(ctrl_reg) |-> mic_sense_ramp_rate == ctrl_reg[5:4])
        else $error("ramp rate differs from the rate field");
    a_ramp_needs_jack: assert property (
        mic_sense_ramp_on |-> jack_present)
        else $error("sense ramp running with no jack");
    a_pause_quiet: assert property (
        button_meas_req |-> jack_four_pole
                            && !(ctrl_reg[0] && $past(ctrl_reg[0])))
        else $error("button measurement while paused");
    a_btn_a_class: assert property (
        btn_valid_in && jack_present && jack_four_pole && !ctrl_reg[0]
        |=> button_a_pressed == ($past(btn_code_in) < $past(ad_reg)))
        else $error("button A classification wrong");
    a_btn_d_class: assert property (
        btn_valid_in && jack_present && jack_four_pole && !ctrl_reg[0]
        |=> button_d_pressed == ($past(btn_code_in) >= $past(ad_reg)
                                 && $past(btn_code_in) < $past(db_reg)))
        else $error("button D classification wrong");
    a_disabled_quiet: assert property (
        jack_inserted_evt || jack_removed_evt |-> en_reg)
        else $error("jack event while detection disabled");
    a_present_follows: assert property (
        jack_removed_evt |=> !jack_present)
        else $error("jack still present after removal");
endmodule : adb_accdet_asserts
bind adb_accdet adb_accdet_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .jack_det_in, .btn_valid_in, .btn_code_in, .jack_present,
    .jack_four_pole, .jack_inserted_evt, .jack_removed_evt,
    .detect_complete_evt, .button_a_pressed, .button_d_pressed,
    .button_meas_req, .mic_sense_ramp_on, .mic_sense_ramp_rate);
`default_nettype wire

/* File: tb/adb_jack_model.sv */
`timescale 1ns/1ps
`default_nettype none
module adb_jack_model (
    input  wire logic       pclk,
    input  wire logic       plug,
    input  wire logic       mic,
    input  wire logic       pressed,
    input  wire logic [7:0] press_code,
    input  wire logic       meas_req,
    output logic            jack_det_in,
    output logic            mic_detect_in,
    output logic            btn_valid_in,
    output logic      [7:0] btn_code_in
);
    // Known levels before the first edge
    initial
    begin
        jack_det_in   = 1'b0;
        mic_detect_in = 1'b0;
        btn_valid_in  = 1'b0;
        btn_code_in   = 8'h00;
    end

    // Contacts settle one cycle after the plug moves
    always @(posedge pclk)
    begin
        jack_det_in   <= plug;
        mic_detect_in <= plug && mic;
        // A reading is offered only when the device asks for one
        btn_valid_in  <= meas_req && pressed && plug;
        // Between readings the code lines toggle, so stale data never passes
        btn_code_in   <= (meas_req && pressed) ? press_code : ~btn_code_in;
    end
endmodule : adb_jack_model
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import adb_pkg::*;
;
    localparam int T = 4;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic        jack_det_in, mic_detect_in, btn_valid_in, e;
    logic [7:0]  btn_code_in, press_code, thr_a, thr_d;
    logic        jack_present, jack_four_pole, jack_inserted_evt;
    logic        jack_removed_evt, detect_complete_evt, button_a_pressed;
    logic        button_d_pressed, button_meas_req, mic_sense_ramp_on;
    logic [1:0]  mic_sense_ramp_rate;
    logic        plug, mic, pressed;
    int          fails, num_checks, n;

    adb_accdet #(.TICK_CYCLES(T)) u_dut (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .jack_det_in,
        .mic_detect_in, .btn_valid_in, .btn_code_in, .jack_present,
        .jack_four_pole, .jack_inserted_evt, .jack_removed_evt,
        .detect_complete_evt, .button_a_pressed, .button_d_pressed,
        .button_meas_req, .mic_sense_ramp_on, .mic_sense_ramp_rate);
    adb_jack_model u_jack (.pclk, .plug, .mic, .pressed, .press_code,
        .meas_req(button_meas_req), .jack_det_in, .mic_detect_in,
        .btn_valid_in, .btn_code_in);

    always #20 pclk = ~pclk;

    task check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    function automatic logic sel(input int k);
        case (k)
            0: return pready;
            1: return jack_inserted_evt;
            2: return jack_removed_evt;
            3: return detect_complete_evt;
            default: return btn_valid_in;
        endcase
    endfunction : sel

    // Bounded wait; the count tells the caller how long it took
    task wait_for(input int k, output int cnt);
        cnt = 0;
        do
        begin
            @(posedge pclk);
            cnt++;
        end
        while (sel(k) !== 1'b1 && cnt < 6000);
        // A wait that runs out is a failure
        if (sel(k) !== 1'b1)
            fails++;
    endtask : wait_for

    // One APB transfer; an idle edge follows so psel is never reassigned
    task apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {idx, 2'b00};
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        wait_for(0, n);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task t_regs;
        apb(0, IDX_CTRL, 0);
        check(q, 32'h0000_0034);
        apb(0, IDX_THR_AD, 0);
        check(q, 32'h0000_000a);
        apb(0, IDX_THR_DB, 0);
        check(q, 32'h0000_0016);
        apb(0, IDX_ENABLE, 0);
        check(q, 32'h0000_0000);
        apb(1, 10'h0e0, 32'h0000_00ff);
        apb(0, 10'h0e0, 0);
        check({q[30:0], e}, 32'h0000_0001);
        $display("test regs done");
    endtask : t_regs

    task t_disabled;
        plug <= 1'b1;
        repeat (300) @(posedge pclk);
        check(jack_present, 0);
        plug <= 1'b0;
        repeat (10) @(posedge pclk);
        $display("test disabled done");
    endtask : t_disabled

    // Bounce mid-debounce must restart the insertion count
    task t_three_pole;
        apb(1, IDX_ENABLE, 32'h0000_0001);
        apb(1, IDX_CTRL, 32'h0000_0040);
        plug <= 1'b1;
        repeat (12) @(posedge pclk);
        plug <= 1'b0;
        repeat (3) @(posedge pclk);
        plug <= 1'b1;
        wait_for(1, n);
        check(n >= 5 * T && n <= 6 * T + 6, 1);
        @(posedge pclk);
        check({mic_sense_ramp_on, mic_sense_ramp_rate}, 32'h4);
        wait_for(3, n);
        check(n >= 32 * T - 1 && n <= 34 * T + 6, 1);
        check(jack_four_pole, 0);
        plug <= 1'b0;
        wait_for(2, n);
        check(n >= 5 * T && n <= 6 * T + 6, 1);
        @(posedge pclk);
        check(jack_present, 0);
        $display("test three pole done");
    endtask : t_three_pole

    task press(input logic [7:0] c);
        press_code <= c;
        @(posedge pclk);
        wait_for(4, n);
        @(posedge pclk);
        check(button_a_pressed, c < thr_a);
        check(button_d_pressed, c >= thr_a && c < thr_d);
    endtask : press

    task t_four_pole;
        thr_a = 8'(256 * 300 / (300 + 2260));
        thr_d = 8'(256 * 700 / (700 + 2260));
        apb(1, IDX_THR_AD, {24'h0, thr_a});
        apb(1, IDX_THR_DB, {24'h0, thr_d});
        apb(1, IDX_CTRL, 32'h0000_0092);
        mic  <= 1'b1;
        plug <= 1'b1;
        wait_for(1, n);
        check(n >= 10 * T && n <= 11 * T + 6, 1);
        wait_for(3, n);
        check(n >= 128 * T - 1 && n <= 130 * T + 8, 1);
        check(jack_four_pole, 1);
        pressed <= 1'b1;
        press(thr_a - 8'h01);
        press(thr_a);
        press(thr_d - 8'h01);
        press(thr_d);
        apb(1, IDX_CTRL, 32'h0000_0093);
        n = 0;
        repeat (100)
        begin
            @(posedge pclk);
            n += int'(button_meas_req === 1'b1);
        end
        check(n, 0);
        plug <= 1'b0;
        wait_for(2, n);
        check(n >= 10 * T && n <= 11 * T + 6, 1);
        $display("test four pole done");
    endtask : t_four_pole

    task print_verdict;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict

    // Whole run is under 3000 cycles; allow generous slack
    initial
    begin
        #400000;
        fails++;
        print_verdict;
    end

    initial
    begin
        pclk = 0;
        presetn = 0;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 0;
        pwdata = 0;
        plug = 0;
        mic = 0;
        pressed = 0;
        press_code = 0;
        fails = 0;
        num_checks = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs;
        t_disabled;
        t_three_pole;
        t_four_pole;
        print_verdict;
    end
endmodule : tb_top
`default_nettype wire
